// ---- include/tcp_defs.vh ----
// Constants of the two-channel timer: register byte addresses, field positions,
// reset values and the counter clock-select encoding.
// Assumes an APB slave with 32-bit data and byte-wide registers in the low lanes.
`ifndef TCP_DEFS_VH
`define TCP_DEFS_VH

`define TCP_ADDR_TSC 8'h00
`define TCP_ADDR_CNTH 8'h04
`define TCP_ADDR_CNTL 8'h08
`define TCP_ADDR_MODH 8'h0C
`define TCP_ADDR_MODL 8'h10
`define TCP_ADDR_CH_BASE 8'h14
`define TCP_ADDR_CH_STRIDE 8'h0C
`define TCP_SUB_CSC 8'h00
`define TCP_SUB_VH 8'h04
`define TCP_SUB_VL 8'h08

// Timer status/control fields
`define TCP_TSC_FLAG 7
`define TCP_TSC_IE 6
`define TCP_TSC_CALIGN 5
`define TCP_TSC_CLKS_HI 4
`define TCP_TSC_CLKS_LO 3

// Channel status/control fields
`define TCP_CSC_FLAG 7
`define TCP_CSC_IE 6
`define TCP_CSC_MODE_B 5
`define TCP_CSC_MODE_A 4
`define TCP_CSC_ELS_B 3
`define TCP_CSC_ELS_A 2

`define TCP_CLKS_OFF 2'h0
`define TCP_CLKS_BUS 2'h1
`define TCP_CLKS_FIXED 2'h2
`define TCP_CLKS_EXT 2'h3

`define TCP_RST_CTL 8'h00
`define TCP_RST_WORD 16'h0000
`define TCP_FREE_TERM 16'hFFFF

`endif

// ---- design/tcp_flag.v ----
// One event flag with the two-step clear: read while set, then write zero.
// Assumes the caller pulses rd_seen and wr_zero for one cycle per access.
`timescale 1ns/1ps
module tcp_flag (
  input wire clk,
  input wire rst_n,
  input wire set_evt,
  input wire rd_seen,
  input wire wr_zero,
  output reg flag_ff
);

  reg arm_ff;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      flag_ff <= 1'b0;
      arm_ff <= 1'b0;
    end
    else
    begin
      // A new event re-opens the sequence and wins over a clear
      if (set_evt)
      begin
        flag_ff <= 1'b1;
        arm_ff <= 1'b0;
      end
      else if (wr_zero && arm_ff)
      begin
        flag_ff <= 1'b0;
        arm_ff <= 1'b0;
      end
      else if (rd_seen && flag_ff)
        arm_ff <= 1'b1;
    end
  end

endmodule

// ---- design/tcp_timer.v ----
// Two-channel 16-bit timer: capture, compare, edge and center PWM, APB registers.
// Assumes pins and tick inputs are synchronous to clk; one byte register per word.
`timescale 1ns/1ps
`include "tcp_defs.vh"
module tcp_timer (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_ff,
  output reg pready_ff,
  output reg pslverr_ff,
  input wire fixed_tick,
  input wire ext_clk_in,
  input wire background_debug_state,
  input wire [1:0] ch_pin_in,
  output reg [1:0] ch_pin_out_ff,
  output reg [1:0] ch_pin_oe_ff,
  output reg overflow_irq_ff,
  output reg [1:0] channel_irq_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg [15:0] cnt_ff;
  reg up_ff;
  reg [15:0] mod_ff;
  reg overflow_interrupt_enable_ff;
  reg center_align_select_ff;
  reg [1:0] clock_select_ff;
  reg ext_prev_ff;
  reg [15:0] ch_ctl_ff;
  reg [31:0] val_ff;
  reg [31:0] wbuf_ff;
  reg [1:0] wb_hi_ff;
  reg [1:0] wb_lo_ff;
  reg [1:0] pend_ff;
  reg [31:0] coh_buf_ff;
  reg [1:0] coh_vld_ff;
  reg [1:0] pin_prev_ff;
  wire overflow_flag;
  wire [1:0] channel_event_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function [7:0] ch_addr;
    input integer n;
    input [7:0] sub;
    begin
      ch_addr = `TCP_ADDR_CH_BASE + n[7:0] * `TCP_ADDR_CH_STRIDE + sub;
    end
  endfunction

  function [15:0] set_byte;
    input [15:0] word;
    input hi;
    input [7:0] b;
    begin
      set_byte = hi ? {b, word[7:0]} : {word[15:8], b};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: one wait state, reads sampled as pready rises

  wire acc_go = psel & penable & ~pready_ff;
  wire rd_go = acc_go & ~pwrite;
  wire wr_do = psel & penable & pready_ff & pwrite;
  wire [7:0] wbyte = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Counter

  reg tick;
  reg [15:0] term;
  reg [15:0] nxt_cnt;
  reg nxt_up;
  reg ovf_evt;
  reg ld_pt;

  always @*
  begin
    case (clock_select_ff)
      `TCP_CLKS_BUS: tick = 1'b1;
      `TCP_CLKS_FIXED: tick = fixed_tick;
      `TCP_CLKS_EXT: tick = ext_clk_in & ~ext_prev_ff;
      default: tick = 1'b0;
    endcase
    // Counter freezes while the debug state is active
    tick = tick & ~background_debug_state;
    term = (mod_ff == `TCP_RST_WORD) ? `TCP_FREE_TERM : mod_ff;
    nxt_cnt = cnt_ff;
    nxt_up = up_ff;
    ovf_evt = 1'b0;
    ld_pt = tick & up_ff & (cnt_ff == term - 16'h0001);
    if (tick)
    begin
      if (center_align_select_ff)
      begin
        if (up_ff)
        begin
          if (cnt_ff >= mod_ff)
          begin
            nxt_cnt = cnt_ff - 16'h0001;
            nxt_up = 1'b0;
            ovf_evt = 1'b1;
          end
          else
            nxt_cnt = cnt_ff + 16'h0001;
        end
        else if (cnt_ff == `TCP_RST_WORD)
        begin
          nxt_cnt = 16'h0001;
          nxt_up = 1'b1;
        end
        else
          nxt_cnt = cnt_ff - 16'h0001;
      end
      else
      begin
        nxt_up = 1'b1;
        if (cnt_ff == term)
        begin
          nxt_cnt = `TCP_RST_WORD;
          ovf_evt = 1'b1;
        end
        else
          nxt_cnt = cnt_ff + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel events and pin levels

  reg [1:0] cap_evt;
  reg [1:0] match_evt;
  reg [1:0] is_cap;
  reg [1:0] is_oc;
  reg [1:0] nxt_out;
  reg [1:0] nxt_oe;
  reg [1:0] rise;
  reg [1:0] fall;
  reg [7:0] c;
  reg [15:0] v;
  integer i;

  always @*
  begin
    c = 8'h00;
    v = 16'h0000;
    for (i = 0; i < 2; i = i + 1)
    begin
      c = ch_ctl_ff[i*8 +: 8];
      v = val_ff[i*16 +: 16];
      rise[i] = ch_pin_in[i] & ~pin_prev_ff[i];
      fall[i] = ~ch_pin_in[i] & pin_prev_ff[i];
      is_cap[i] = ~center_align_select_ff & ~c[`TCP_CSC_MODE_B] & ~c[`TCP_CSC_MODE_A];
      is_oc[i] = ~center_align_select_ff & ~c[`TCP_CSC_MODE_B] & c[`TCP_CSC_MODE_A];
      cap_evt[i] = is_cap[i] & ((c[`TCP_CSC_ELS_A] & rise[i]) | (c[`TCP_CSC_ELS_B] & fall[i]));
      match_evt[i] = ~is_cap[i] & tick & (nxt_cnt == v);
      nxt_out[i] = ch_pin_out_ff[i];
      nxt_oe[i] = ~is_cap[i] & (c[`TCP_CSC_ELS_B] | c[`TCP_CSC_ELS_A]);
      if (!nxt_oe[i])
        nxt_out[i] = 1'b0;
      else if (is_oc[i])
      begin
        if (match_evt[i])
        begin
          case ({c[`TCP_CSC_ELS_B], c[`TCP_CSC_ELS_A]})
            2'h1: nxt_out[i] = ~ch_pin_out_ff[i];
            2'h2: nxt_out[i] = 1'b0;
            2'h3: nxt_out[i] = 1'b1;
            default: nxt_out[i] = ch_pin_out_ff[i];
          endcase
        end
      end
      else if (!center_align_select_ff)
      begin
        // Match after overflow so a zero value never shows an active count
        if (tick && nxt_cnt == `TCP_RST_WORD)
          nxt_out[i] = (v != `TCP_RST_WORD) ^ c[`TCP_CSC_ELS_A];
        if (match_evt[i])
          nxt_out[i] = c[`TCP_CSC_ELS_A];
      end
      else
      begin
        if (v == `TCP_RST_WORD || v[15])
          nxt_out[i] = c[`TCP_CSC_ELS_A];
        else if (v > mod_ff && mod_ff != `TCP_RST_WORD)
          nxt_out[i] = ~c[`TCP_CSC_ELS_A];
        else if (match_evt[i])
          nxt_out[i] = nxt_up ? c[`TCP_CSC_ELS_A] : ~c[`TCP_CSC_ELS_A];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  reg [7:0] rd_byte;
  reg mapped;
  reg [1:0] rd_csc;
  reg [1:0] rd_val;
  reg [1:0] rd_hi;
  reg [15:0] rv;
  integer j;

  always @*
  begin
    rv = 16'h0000;
    rd_byte = 8'h00;
    mapped = 1'b1;
    rd_csc = 2'h0;
    rd_val = 2'h0;
    rd_hi = 2'h0;
    case (paddr)
      `TCP_ADDR_TSC: rd_byte = {overflow_flag, overflow_interrupt_enable_ff, center_align_select_ff,
                                clock_select_ff, 3'h0};
      `TCP_ADDR_CNTH: rd_byte = cnt_ff[15:8];
      `TCP_ADDR_CNTL: rd_byte = cnt_ff[7:0];
      `TCP_ADDR_MODH: rd_byte = mod_ff[15:8];
      `TCP_ADDR_MODL: rd_byte = mod_ff[7:0];
      default: mapped = 1'b0;
    endcase
    for (j = 0; j < 2; j = j + 1)
    begin
      if (paddr == ch_addr(j, `TCP_SUB_CSC))
      begin
        mapped = 1'b1;
        rd_csc[j] = 1'b1;
        rd_byte = {channel_event_flag[j], ch_ctl_ff[j*8+6 -: 5], 2'h0};
      end
      if (paddr == ch_addr(j, `TCP_SUB_VH) || paddr == ch_addr(j, `TCP_SUB_VL))
      begin
        mapped = 1'b1;
        rd_val[j] = 1'b1;
        rd_hi[j] = (paddr == ch_addr(j, `TCP_SUB_VH));
        // Second read of a captured pair returns the snapshot
        rv = (coh_vld_ff[j] && is_cap[j]) ? coh_buf_ff[j*16 +: 16] : val_ff[j*16 +: 16];
        rd_byte = rd_hi[j] ? rv[15:8] : rv[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags

  tcp_flag u_ovf_flag (
    .clk(clk),
    .rst_n(rst_n),
    .set_evt(ovf_evt),
    .rd_seen(rd_go & (paddr == `TCP_ADDR_TSC)),
    .wr_zero(wr_do & (paddr == `TCP_ADDR_TSC) & ~wbyte[`TCP_TSC_FLAG]),
    .flag_ff(overflow_flag)
  );

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_chf
      tcp_flag u_ch_flag (
        .clk(clk),
        .rst_n(rst_n),
        .set_evt(cap_evt[g] | match_evt[g]),
        .rd_seen(rd_go & rd_csc[g]),
        .wr_zero(wr_do & rd_csc[g] & ~wbyte[`TCP_CSC_FLAG]),
        .flag_ff(channel_event_flag[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  integer k;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      cnt_ff <= `TCP_RST_WORD;
      up_ff <= 1'b1;
      mod_ff <= `TCP_RST_WORD;
      overflow_interrupt_enable_ff <= 1'b0;
      center_align_select_ff <= 1'b0;
      clock_select_ff <= `TCP_CLKS_OFF;
      ext_prev_ff <= 1'b0;
      ch_ctl_ff <= {2{`TCP_RST_CTL}};
      val_ff <= 32'h00000000;
      wbuf_ff <= 32'h00000000;
      wb_hi_ff <= 2'h0;
      wb_lo_ff <= 2'h0;
      pend_ff <= 2'h0;
      coh_buf_ff <= 32'h00000000;
      coh_vld_ff <= 2'h0;
      pin_prev_ff <= 2'h0;
      ch_pin_out_ff <= 2'h0;
      ch_pin_oe_ff <= 2'h0;
      overflow_irq_ff <= 1'b0;
      channel_irq_ff <= 2'h0;
    end
    else
    begin
      pready_ff <= acc_go;
      if (acc_go)
      begin
        prdata_ff <= {24'h000000, rd_byte};
        pslverr_ff <= ~mapped;
      end
      ext_prev_ff <= ext_clk_in;
      pin_prev_ff <= ch_pin_in;
      ch_pin_out_ff <= nxt_out;
      ch_pin_oe_ff <= nxt_oe;
      overflow_irq_ff <= overflow_flag & overflow_interrupt_enable_ff;
      channel_irq_ff <= channel_event_flag & {ch_ctl_ff[8+`TCP_CSC_IE], ch_ctl_ff[`TCP_CSC_IE]};
      cnt_ff <= nxt_cnt;
      up_ff <= nxt_up;
      if (wr_do)
      begin
        case (paddr)
          `TCP_ADDR_TSC:
          begin
            overflow_interrupt_enable_ff <= wbyte[`TCP_TSC_IE];
            center_align_select_ff <= wbyte[`TCP_TSC_CALIGN];
            clock_select_ff <= wbyte[`TCP_TSC_CLKS_HI:`TCP_TSC_CLKS_LO];
          end
          `TCP_ADDR_CNTH, `TCP_ADDR_CNTL:
          begin
            cnt_ff <= `TCP_RST_WORD;
            up_ff <= 1'b1;
          end
          `TCP_ADDR_MODH: mod_ff <= {wbyte, mod_ff[7:0]};
          `TCP_ADDR_MODL: mod_ff <= {mod_ff[15:8], wbyte};
          default: ;
        endcase
      end
      for (k = 0; k < 2; k = k + 1)
      begin
        // Buffered value takes over at the mode's load point
        if (pend_ff[k] && ((is_oc[k] && tick) || (!is_oc[k] && ld_pt)))
        begin
          val_ff[k*16 +: 16] <= wbuf_ff[k*16 +: 16];
          pend_ff[k] <= 1'b0;
        end
        if (cap_evt[k])
          val_ff[k*16 +: 16] <= cnt_ff;
        if (rd_go && rd_val[k] && is_cap[k])
        begin
          coh_vld_ff[k] <= ~coh_vld_ff[k];
          if (!coh_vld_ff[k])
            coh_buf_ff[k*16 +: 16] <= val_ff[k*16 +: 16];
        end
        if (wr_do && rd_csc[k])
        begin
          ch_ctl_ff[k*8 +: 8] <= {1'b0, wbyte[6:2], 2'h0};
          wb_hi_ff[k] <= 1'b0;
          wb_lo_ff[k] <= 1'b0;
          coh_vld_ff[k] <= 1'b0;
        end
        // Capture mode ignores value writes entirely
        if (wr_do && rd_val[k] && !is_cap[k])
        begin
          if (background_debug_state)
            // Debug writes bypass the buffer and leave the byte sequence alone
            val_ff[k*16 +: 16] <= set_byte(val_ff[k*16 +: 16], rd_hi[k], wbyte);
          else
          begin
            wbuf_ff[k*16 +: 16] <= set_byte(wbuf_ff[k*16 +: 16], rd_hi[k], wbyte);
            if ((rd_hi[k] && wb_lo_ff[k]) || (!rd_hi[k] && wb_hi_ff[k]))
            begin
              wb_hi_ff[k] <= 1'b0;
              wb_lo_ff[k] <= 1'b0;
              if (clock_select_ff == `TCP_CLKS_OFF)
                val_ff[k*16 +: 16] <= set_byte(wbuf_ff[k*16 +: 16], rd_hi[k], wbyte);
              else
                pend_ff[k] <= 1'b1;
            end
            else if (rd_hi[k])
              wb_hi_ff[k] <= 1'b1;
            else
              wb_lo_ff[k] <= 1'b1;
          end
        end
      end
    end
  end

endmodule

// ---- verification/tcp_properties.sv ----
// Port checker of the two-channel timer, bound into every instance.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
module tcp_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_ff,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  input wire logic [1:0] ch_pin_out_ff,
  input wire logic [1:0] ch_pin_oe_ff,
  input wire logic overflow_irq_ff,
  input wire logic [1:0] channel_irq_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && !pready_ff;
  endsequence
  a_ready_wait: assert property (s_setup ##1 s_access |=> pready_ff)
    else $error("no ready after access");
  a_unmapped_err: assert property (pready_ff && (paddr[1:0] != 2'h0 || paddr > 8'h28) |-> pslverr_ff)
    else $error("unmapped access without error");
  a_reset_idle: assert property ($rose(rst_n) |-> ch_pin_oe_ff == 2'h0 && !overflow_irq_ff)
    else $error("outputs active after reset");
  a_pin_released: assert property ((ch_pin_out_ff & ~ch_pin_oe_ff) == 2'h0)
    else $error("released pin driven");
  a_read_upper: assert property (pready_ff && !pwrite |-> prdata_ff[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_chirq_follows: assert property (pready_ff && !pwrite && paddr == 8'h14 && prdata_ff[7:6] == 2'h3
    |-> ##[0:1] channel_irq_ff[0])
    else $error("channel irq low with flag and enable");
  a_ovfirq_follows: assert property (pready_ff && !pwrite && paddr == 8'h00 && prdata_ff[7:6] == 2'h3
    |-> ##[0:1] overflow_irq_ff)
    else $error("overflow irq low with flag and enable");
  a_irq_masked: assert property (pready_ff && pwrite && paddr == 8'h14 && !pwdata[6] |=> ##1 !channel_irq_ff[0])
    else $error("channel irq high with enable clear");
endmodule
bind tcp_timer tcp_properties u_props (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata_ff, .pready_ff, .pslverr_ff, .ch_pin_out_ff, .ch_pin_oe_ff, .overflow_irq_ff, .channel_irq_ff);

// ---- verification/tcp_pin_model.sv ----
// Far side of the channel pins: a source giving one short pulse per request.
// Assumes the timer drives a pin only while its enable is high.
`timescale 1ns/1ps
module tcp_pin_model (
  input wire logic clk,
  input wire logic [1:0] pulse_req,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output wire logic [1:0] pin_level
);
  logic [2:0] sr0_ff = 3'h0;
  logic [2:0] sr1_ff = 3'h0;
  always @(posedge clk)
  begin
    sr0_ff <= {sr0_ff[1:0], pulse_req[0]};
    sr1_ff <= {sr1_ff[1:0], pulse_req[1]};
  end
  // Three cycles high so the pin synchroniser sees one rise and one fall
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & {|sr1_ff, |sr0_ff});
endmodule

// ---- verification/tb.sv ----
// Self-checking bench of the two-channel timer: APB master, tick source, pins.
// Assumes 50 MHz and the one-wait registered APB answer.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, fixed_tick = 1'b0, debug_on = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] pulse_req = 2'h0;
  logic [7:0] rq;
  logic rerr;
  int fail_count = 0, compares = 0;
  wire [31:0] prdata_ff;
  wire pready_ff, pslverr_ff, overflow_irq_ff;
  wire [1:0] ch_pin_in, ch_pin_out_ff, ch_pin_oe_ff, channel_irq_ff;
  always #10 clk = ~clk;
  tcp_timer DUT (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff, .pready_ff,
    .pslverr_ff, .fixed_tick, .ext_clk_in(1'b0), .background_debug_state(debug_on), .ch_pin_in,
    .ch_pin_out_ff, .ch_pin_oe_ff, .overflow_irq_ff, .channel_irq_ff);
  tcp_pin_model u_pins (.clk, .pulse_req, .pin_out(ch_pin_out_ff), .pin_oe(ch_pin_oe_ff), .pin_level(ch_pin_in));
  ////////////////////////////////////////
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", s, e, g);
      fail_count++;
    end
  endtask
  // Request held until pready is seen high, then one idle cycle
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready_ff !== 1'b1 && n++ < 20)
      @(posedge clk);
    fail_count += (n > 20);
    rq = prdata_ff[7:0];
    rerr = pslverr_ff;
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask
  task ticks(input int k);
    fixed_tick <= 1'b1;
    repeat (k) @(posedge clk);
    fixed_tick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task pulse;
    pulse_req[0] <= 1'b1;
    @(posedge clk);
    pulse_req[0] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  ////////////////////////////////////////
  task t_reset;
    chk("pin enables", 0, ch_pin_oe_ff);
    apb(0, 8'h00, 8'h00);
    chk("tsc", 0, rq);
    apb(0, 8'h20, 8'h00);
    chk("csc1", 0, rq);
    apb(0, 8'h30, 8'h00);
    chk("unmapped err", 1, rerr);
    apb(1, 8'h0A, 8'h5A);
    chk("unaligned err", 1, rerr);
    $display("reset test done");
  endtask
  task t_capture;
    apb(1, 8'h08, 8'h00);
    apb(1, 8'h00, 8'h10);
    ticks(7);
    apb(1, 8'h14, 8'h44);
    pulse;
    chk("ch irq", 1, channel_irq_ff[0]);
    apb(0, 8'h18, 8'h00);
    chk("cap high", 0, rq);
    ticks(2);
    pulse;
    apb(0, 8'h1C, 8'h00);
    chk("held low", 8'h07, rq);
    apb(0, 8'h1C, 8'h00);
    chk("cap low", 8'h09, rq);
    apb(1, 8'h1C, 8'hAA);
    apb(0, 8'h1C, 8'h00);
    chk("read only", 8'h09, rq);
    apb(0, 8'h14, 8'h00);
    chk("flag set", 8'hC4, rq);
    apb(1, 8'h14, 8'h44);
    apb(0, 8'h14, 8'h00);
    chk("flag clear", 8'h44, rq);
    chk("irq clear", 0, channel_irq_ff[0]);
    debug_on <= 1'b1;
    ticks(3);
    pulse;
    debug_on <= 1'b0;
    apb(0, 8'h14, 8'h00);
    chk("debug flag", 8'hC4, rq);
    apb(0, 8'h1C, 8'h00);
    chk("frozen cap", 8'h09, rq);
    $display("capture test done");
  endtask
  task t_compare;
    logic p0;
    apb(1, 8'h00, 8'h00);
    apb(1, 8'h08, 8'h00);
    apb(1, 8'h20, 8'h14);
    apb(1, 8'h24, 8'h00);
    apb(1, 8'h28, 8'h05);
    apb(1, 8'h00, 8'h10);
    p0 = ch_pin_out_ff[1];
    ticks(4);
    chk("pin early", p0, ch_pin_out_ff[1]);
    ticks(1);
    chk("pin toggle", !p0, ch_pin_out_ff[1]);
    apb(0, 8'h20, 8'h00);
    chk("cmp flag", 8'h94, rq);
    apb(1, 8'h00, 8'h00);
    ticks(3);
    apb(0, 8'h08, 8'h00);
    chk("stopped cnt", 8'h05, rq);
    apb(1, 8'h24, 8'h00);
    apb(1, 8'h20, 8'h14);
    apb(1, 8'h28, 8'h03);
    apb(0, 8'h28, 8'h00);
    chk("pair restart", 8'h05, rq);
    $display("compare test done");
  endtask
  // Counts high cycles over whole periods once the new value has landed
  task pwm_run(input logic [7:0] tsc, csc, md, input logic [15:0] v, input int e);
    int hi;
    hi = 0;
    apb(1, 8'h00, tsc & 8'hE7);
    apb(1, 8'h10, md);
    apb(1, 8'h08, 8'h00);
    apb(1, 8'h14, csc);
    apb(1, 8'h18, v[15:8]);
    apb(1, 8'h1C, v[7:0]);
    apb(1, 8'h00, tsc);
    measure(e);
  endtask
  task measure(input int e);
    int hi;
    hi = 0;
    repeat (20) @(posedge clk);
    repeat (80)
    begin
      @(posedge clk);
      hi += ch_pin_out_ff[0];
    end
    chk("pin driven", 1, ch_pin_oe_ff[0]);
    chk("high cycles", e, hi);
  endtask
  task t_edge_aligned_pwm;
    pwm_run(8'h48, 8'h28, 8'h03, 16'h0000, 0);
    chk("ovf irq", 1, overflow_irq_ff);
    apb(0, 8'h00, 8'h00);
    chk("ovf flag", 8'hC8, rq);
    pwm_run(8'h48, 8'h28, 8'h03, 16'h0001, 20);
    apb(1, 8'h18, 8'h00);
    apb(1, 8'h1C, 8'h04);
    measure(80);
    pwm_run(8'h48, 8'h2C, 8'h03, 16'h0001, 60);
    pwm_run(8'h48, 8'h28, 8'h03, 16'h0004, 80);
    $display("edge pwm test done");
  endtask
  task t_center_aligned_pwm;
    apb(1, 8'h20, 8'h00);
    pwm_run(8'h28, 8'h08, 8'h04, 16'h0001, 20);
    pwm_run(8'h28, 8'h0C, 8'h04, 16'h0001, 60);
    pwm_run(8'h28, 8'h08, 8'h04, 16'h0005, 80);
    pwm_run(8'h28, 8'h08, 8'h04, 16'h8001, 0);
    pwm_run(8'h28, 8'h08, 8'h04, 16'h0000, 0);
    $display("center pwm test done");
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_capture;
    t_compare;
    t_edge_aligned_pwm;
    t_center_aligned_pwm;
    summarize;
  end
  // Whole run is about 1500 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize;
  end
endmodule
